/* verilog/ott_regs.svh */
// Register offsets, field positions, reset values and timing constants
`ifndef OTT_REGS_SVH
`define OTT_REGS_SVH
`define OTT_A_CTRL      4'h0
`define OTT_A_PICKUP    4'h1
`define OTT_A_DEF_DLY   4'h2
`define OTT_A_TMULT     4'h3
`define OTT_A_RST_DLY   4'h4
`define OTT_A_UMIN      4'h5
`define OTT_A_NOMINAL   4'h6
`define OTT_A_ANGLE     4'h7
`define OTT_A_VR_MAX    4'h8
`define OTT_A_TABLE     4'h9
`define OTT_A_STATUS    4'ha
`define OTT_A_TIMER     4'hb
`define OTT_A_DELAY     4'hc
`define OTT_C_EN        0
`define OTT_C_CURVE     1
`define OTT_C_RMODE     3
`define OTT_C_DIR       5
`define OTT_C_METH      7
`define OTT_C_PG        9
`define OTT_C_VR        10
`define OTT_C_NOREF_BLK 11
`define OTT_T_SEL       31
`define OTT_T_IDX       24
`define OTT_CTRL_RST    12'h000
`define OTT_TMULT_RST   16'h0100
`define OTT_CAP_PU_MULT 22'h14
`define OTT_CAP_IN_MULT 22'h28
`define OTT_RATIO_FRAC  4
`define OTT_TM_FRAC     8
`define OTT_VR_FLOOR_SH 2
`define OTT_RST_PWR_CYC 2
`define OTT_INRUSH_MS   30
`endif

/* verilog/ott_pkg.sv */
// Mode and state types of the overcurrent trip timing block
package ott_pkg;
   typedef enum logic [1:0] {
      OTT_CURVE_DEFINITE_TIME_CURVE  = 2'b00,
      OTT_CURVE_INV   = 2'b01,
      OTT_CURVE_THERM = 2'b10
   } ott_curve_t;
   typedef enum logic [1:0] {
      OTT_RST_INST = 2'b00,
      OTT_RST_DEF  = 2'b01,
      OTT_RST_INV  = 2'b10
   } ott_rmode_t;
   typedef enum logic [1:0] {
      OTT_DIR_NONE = 2'b00,
      OTT_DIR_FWD  = 2'b01,
      OTT_DIR_REV  = 2'b10
   } ott_dir_t;
   typedef enum logic [1:0] {
      OTT_METH_FUND = 2'b00,
      OTT_METH_RMS  = 2'b01,
      OTT_METH_NEG  = 2'b10
   } ott_meth_t;
   typedef enum logic [2:0] {
      OTT_ST_IDLE  = 3'b000,
      OTT_ST_DIV_I = 3'b001,
      OTT_ST_DIV_C = 3'b010,
      OTT_ST_EVAL  = 3'b011,
      OTT_ST_TIMER = 3'b100
   } ott_state_t;
endpackage : ott_pkg

/* verilog/ott_div.sv */
// Iterative restoring divider, one quotient bit per clock
module ott_div #(
   parameter int W  = 28,
   parameter int DW = 16
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          start,
   input  wire logic [W-1:0]  dividend,
   input  wire logic [DW-1:0] divisor,
   output logic [W-1:0]       quotient,
   output logic               done
);
   localparam int CW = $clog2(W + 1);
   initial if (W < 2 || DW < 2) $error("ott_div: widths too small");
   typedef struct packed {
      logic          busy;
      logic [CW-1:0] cnt;
      logic [DW:0]   rem;
      logic [W-1:0]  quo;
      logic          done;
   } ott_div_st_t;
   ott_div_st_t st, nx;
   logic [DW:0] r;
   // Zero divisor yields all ones, a saturated ratio
   always_comb
   begin
      nx = st;
      nx.done = 1'b0;
      r = {st.rem[DW-1:0], st.quo[W-1]};
      if (start)
      begin
         nx.busy = 1'b1;
         nx.cnt = CW'(W);
         nx.rem = '0;
         nx.quo = dividend;
      end
      else if (st.busy)
      begin
         if (r >= {1'b0, divisor})
         begin
            nx.rem = r - {1'b0, divisor};
            nx.quo = {st.quo[W-2:0], 1'b1};
         end
         else
         begin
            nx.rem = r;
            nx.quo = {st.quo[W-2:0], 1'b0};
         end
         nx.cnt = st.cnt - CW'(1);
         if (st.cnt == CW'(1))
         begin
            nx.busy = 1'b0;
            nx.done = 1'b1;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         st <= '0;
      else
         st <= nx;
   assign quotient = st.quo;
   assign done     = st.done;
endmodule : ott_div

/* verilog/ott_curve_tbl.sv */
// Software-loaded curve table with two asynchronous read ports
module ott_curve_tbl #(
   parameter int DEPTH = 64,
   parameter int AW    = 6,
   parameter int VW    = 16
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [VW-1:0] wr_data,
   input  wire logic [AW-1:0] rd_addr_a,
   input  wire logic [AW-1:0] rd_addr_b,
   output logic [VW-1:0]      rd_data_a,
   output logic [VW-1:0]      rd_data_b
);
   initial if (DEPTH > (1 << AW)) $error("ott_curve_tbl: AW too small");
   typedef struct packed {
      logic [DEPTH-1:0][VW-1:0] mem;
   } ott_tbl_st_t;
   ott_tbl_st_t st, nx;
   always_comb
   begin
      nx = st;
      if (wr_en && (int'(wr_addr) < DEPTH))
         nx.mem[wr_addr] = wr_data;
   end
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         st <= '0;
      else
         st <= nx;
   assign rd_data_a = (int'(rd_addr_a) < DEPTH) ? st.mem[rd_addr_a] : '0;
   assign rd_data_b = (int'(rd_addr_b) < DEPTH) ? st.mem[rd_addr_b] : '0;
endmodule : ott_curve_tbl

/* verilog/ott_overcurrent_trip.sv */
// Phase overcurrent element: pickup, curve timing, reset and trip
//
// The address-and-strobe port and the address map are this design's own decisions.
`include "ott_regs.svh"
//
// Operation
// - Timer runs only while current exceeds pickup
// - Definite time trips after definite delay
// - Inverse delay from multiplier, curve, ratio
// - Instantaneous reset clears timer within two cycles
// - Definite reset holds timer for reset delay
// - Inverse reset from curve, not for definite
// - Definite curve always resets with zero delay
// - Inverse curve enforces both minimum delays, thermal curve neither
// - User minimum timer must expire; zero disables
// - Current cap is min of twenty/forty multiples
// - Floor delay is curve delay at cap
// - Fundamental, RMS or negative sequence measurement
// - Non-directional mode ignores direction
// - Forward/reverse qualify pickup by characteristic angle
// - Polarise each phase by opposite line voltage
// - No reference voltage: non-directional or block
// - Voltage restraint lowers pickup on voltage drop
// - Restraint voltage phase-phase or phase-ground
// - Inverse reset is tau over one-minus-ratio power
module ott_overcurrent_trip #(
   parameter int SAMPLE_DIV = 25000
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [31:0]      rdata,
   input  wire logic [15:0] phase_a_current,
   input  wire logic [15:0] phase_b_current,
   input  wire logic [15:0] phase_c_current,
   input  wire logic [15:0] phase_a_rms,
   input  wire logic [15:0] phase_b_rms,
   input  wire logic [15:0] phase_c_rms,
   input  wire logic [15:0] negative_sequence_current,
   input  wire logic [15:0] phase_a_angle,
   input  wire logic [15:0] phase_b_angle,
   input  wire logic [15:0] phase_c_angle,
   input  wire logic [15:0] voltage_a_to_b,
   input  wire logic [15:0] voltage_b_to_c,
   input  wire logic [15:0] voltage_c_to_a,
   input  wire logic [15:0] voltage_a_to_b_angle,
   input  wire logic [15:0] voltage_b_to_c_angle,
   input  wire logic [15:0] voltage_c_to_a_angle,
   input  wire logic [15:0] phase_a_voltage,
   input  wire logic [15:0] phase_b_voltage,
   input  wire logic [15:0] phase_c_voltage,
   input  wire logic        ref_voltage_valid,
   input  wire logic        ref_memory_valid,
   output logic             pickup,
   output logic             trip,
   output logic             blocked
);
   initial if (SAMPLE_DIV < 64 || SAMPLE_DIV > 65535)
      $error("ott_overcurrent_trip: SAMPLE_DIV out of range");
   typedef struct packed {
      logic [11:0]        ctrl;
      logic [15:0]        pickup_thr;
      logic [23:0]        def_delay;
      logic [15:0]        time_multiplier;
      logic [23:0]        reset_delay_setting;
      logic [23:0]        user_min_delay;
      logic [15:0]        nominal;
      logic [15:0]        phase_char_angle;
      logic [15:0]        vr_max;
      logic [31:0]        rdata;
      ott_pkg::ott_state_t fsm;
      logic [15:0]        sdiv;
      logic [27:0]        quo_i;
      logic [27:0]        quo_c;
      logic [23:0]        delay;
      logic [23:0]        floor_dly;
      logic [23:0]        rst_dly;
      logic [23:0]        tmr;
      logic [23:0]        min_tmr;
      logic [23:0]        rst_tmr;
      logic               picked;
      logic               blk;
      logic               trip;
   } ott_st_t;
   ott_st_t st, nx;

   ott_pkg::ott_curve_t curve;
   ott_pkg::ott_rmode_t rmode;
   ott_pkg::ott_dir_t   dmode;
   ott_pkg::ott_meth_t  meth;
   assign curve = ott_pkg::ott_curve_t'(st.ctrl[`OTT_C_CURVE +: 2]);
   assign rmode = ott_pkg::ott_rmode_t'(st.ctrl[`OTT_C_RMODE +: 2]);
   assign dmode = ott_pkg::ott_dir_t'(st.ctrl[`OTT_C_DIR +: 2]);
   assign meth  = ott_pkg::ott_meth_t'(st.ctrl[`OTT_C_METH +: 2]);

   logic sample_en;
   assign sample_en = (st.sdiv == 16'(SAMPLE_DIV - 1));

   // Per-phase measurement, restraint and direction
   logic [15:0] ph_i [3];
   logic [15:0] ph_ia [3];
   logic [15:0] ph_va [3];
   logic [15:0] ph_vpp [3];
   logic [15:0] ph_vpg [3];
   logic [2:0]  over;
   logic [2:0]  dir_ok;
   logic        ref_ok;
   logic        blk_now;
   logic        pick_now;
   logic [15:0] i_max;
   assign ph_ia = '{phase_a_angle, phase_b_angle, phase_c_angle};
   // Opposite line voltage polarises each phase
   assign ph_va = '{voltage_b_to_c_angle, voltage_c_to_a_angle,
                    voltage_a_to_b_angle};
   assign ph_vpp = '{voltage_a_to_b, voltage_b_to_c, voltage_c_to_a};
   assign ph_vpg = '{phase_a_voltage, phase_b_voltage, phase_c_voltage};
   assign ref_ok = ref_voltage_valid | ref_memory_valid;
   assign blk_now = (dmode != ott_pkg::OTT_DIR_NONE) && !ref_ok &&
                    st.ctrl[`OTT_C_NOREF_BLK];

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_ph
         logic [15:0] i_fund;
         logic [15:0] i_rms;
         logic [15:0] v_sel;
         logic [15:0] v_cl;
         logic [15:0] v_lo;
         logic [15:0] d_ang;
         logic        fwd;
         assign i_fund = (g == 0) ? phase_a_current :
                         (g == 1) ? phase_b_current : phase_c_current;
         assign i_rms  = (g == 0) ? phase_a_rms :
                         (g == 1) ? phase_b_rms : phase_c_rms;
         assign ph_i[g] = (meth == ott_pkg::OTT_METH_RMS) ? i_rms :
                          (meth == ott_pkg::OTT_METH_NEG) ?
                          negative_sequence_current : i_fund;
         assign v_sel = st.ctrl[`OTT_C_PG] ? ph_vpg[g] : ph_vpp[g];
         // Floor keeps the restrained threshold from reaching zero
         assign v_lo = st.vr_max >> `OTT_VR_FLOOR_SH;
         assign v_cl = (v_sel > st.vr_max) ? st.vr_max :
                       (v_sel < v_lo) ? v_lo : v_sel;
         // Cross-multiplied compare avoids a divider per phase
         assign over[g] = st.ctrl[`OTT_C_VR] ?
                          (32'(ph_i[g]) * 32'(st.vr_max) >
                           32'(st.pickup_thr) * 32'(v_cl)) :
                          (ph_i[g] > st.pickup_thr);
         assign d_ang = ph_ia[g] - ph_va[g] - st.phase_char_angle;
         assign fwd = (d_ang[15] == d_ang[14]);
         assign dir_ok[g] = (dmode == ott_pkg::OTT_DIR_NONE) ||
                            !ref_ok ||
                            (dmode == ott_pkg::OTT_DIR_FWD && fwd) ||
                            (dmode == ott_pkg::OTT_DIR_REV && !fwd);
      end
   endgenerate

   assign pick_now = st.ctrl[`OTT_C_EN] && !blk_now && |(over & dir_ok);
   assign i_max = (ph_i[0] > ph_i[1]) ?
                  ((ph_i[0] > ph_i[2]) ? ph_i[0] : ph_i[2]) :
                  ((ph_i[1] > ph_i[2]) ? ph_i[1] : ph_i[2]);

   // Current cap and the two ratio divisions
   logic [21:0] cap_pu;
   logic [21:0] cap_in;
   logic [21:0] current_cap;
   logic        div_start;
   logic [27:0] div_dvd;
   logic [27:0] div_q;
   logic        div_done;
   assign cap_pu = 22'(st.pickup_thr) * `OTT_CAP_PU_MULT;
   assign cap_in = 22'(st.nominal) * `OTT_CAP_IN_MULT;
   assign current_cap = (cap_pu < cap_in) ? cap_pu : cap_in;
   assign div_start = (st.fsm == ott_pkg::OTT_ST_IDLE && sample_en) ||
                      (st.fsm == ott_pkg::OTT_ST_DIV_I && div_done);
   assign div_dvd = (st.fsm == ott_pkg::OTT_ST_IDLE) ?
                    {8'h00, i_max, 4'h0} :
                    {2'h0, current_cap, 4'h0};

   ott_div #(.W(28), .DW(16)) u_div (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (div_start),
      .dividend (div_dvd),
      .divisor  (st.pickup_thr),
      .quotient (div_q),
      .done     (div_done)
   );

   function automatic logic [5:0] ratio_idx(input logic [27:0] q);
      ratio_idx = (|q[27:10]) ? 6'h3f : q[9:4];
   endfunction : ratio_idx
   function automatic logic [23:0] scale(input logic [15:0] base,
                                         input logic [15:0] tm);
      logic [31:0] p;
      p = 32'(base) * 32'(tm);
      scale = p[31:`OTT_TM_FRAC];
   endfunction : scale
   function automatic logic [23:0] inc(input logic [23:0] v);
      inc = (&v) ? v : v + 24'h000001;
   endfunction : inc

   logic        tw_trip;
   logic        tw_rst;
   logic [15:0] trip_a;
   logic [15:0] trip_b;
   logic [15:0] rst_a;
   assign tw_trip = wr_stb && addr == `OTT_A_TABLE && !wdata[`OTT_T_SEL];
   assign tw_rst  = wr_stb && addr == `OTT_A_TABLE && wdata[`OTT_T_SEL];

   ott_curve_tbl #(.DEPTH(64), .AW(6), .VW(16)) u_trip_tbl (
      .clk       (clk),
      .rst_n     (rst_n),
      .wr_en     (tw_trip),
      .wr_addr   (wdata[`OTT_T_IDX +: 6]),
      .wr_data   (wdata[15:0]),
      .rd_addr_a (ratio_idx(st.quo_i)),
      .rd_addr_b (ratio_idx(st.quo_c)),
      .rd_data_a (trip_a),
      .rd_data_b (trip_b)
   );
   ott_curve_tbl #(.DEPTH(16), .AW(6), .VW(16)) u_rst_tbl (
      .clk       (clk),
      .rst_n     (rst_n),
      .wr_en     (tw_rst),
      .wr_addr   (wdata[`OTT_T_IDX +: 6]),
      .wr_data   (wdata[15:0]),
      .rd_addr_a ({2'h0, st.quo_i[3:0]}),
      .rd_addr_b (6'h00),
      .rd_data_a (rst_a),
      .rd_data_b ()
   );

   // Trip threshold and minimum timer qualification
   logic        is_definite_time_curve;
   logic        is_inv;
   logic [23:0] need;
   logic [23:0] tmr_inc;
   logic [23:0] min_inc;
   logic        min_ok;
   logic [23:0] hold;
   assign is_definite_time_curve = (curve == ott_pkg::OTT_CURVE_DEFINITE_TIME_CURVE);
   assign is_inv  = (curve == ott_pkg::OTT_CURVE_INV);
   assign need = is_definite_time_curve ? st.def_delay :
                 (is_inv && st.floor_dly > st.delay) ?
                 st.floor_dly : st.delay;
   assign tmr_inc = inc(st.tmr);
   assign min_inc = inc(st.min_tmr);
   assign min_ok = !is_inv || st.user_min_delay == 24'h000000 ||
                   min_inc >= st.user_min_delay;
   assign hold = (rmode == ott_pkg::OTT_RST_INV) ? st.rst_dly :
                 st.reset_delay_setting;

   always_comb
   begin
      nx = st;
      nx.rdata = 32'h00000000;
      nx.sdiv = sample_en ? 16'h0000 : st.sdiv + 16'h0001;
      if (wr_stb)
      begin
         case (addr)
            `OTT_A_CTRL:    nx.ctrl = wdata[11:0];
            `OTT_A_PICKUP:  nx.pickup_thr = wdata[15:0];
            `OTT_A_DEF_DLY: nx.def_delay = wdata[23:0];
            `OTT_A_TMULT:   nx.time_multiplier = wdata[15:0];
            `OTT_A_RST_DLY: nx.reset_delay_setting = wdata[23:0];
            `OTT_A_UMIN:    nx.user_min_delay = wdata[23:0];
            `OTT_A_NOMINAL: nx.nominal = wdata[15:0];
            `OTT_A_ANGLE:   nx.phase_char_angle = wdata[15:0];
            `OTT_A_VR_MAX:  nx.vr_max = wdata[15:0];
            default:        nx.ctrl = st.ctrl;
         endcase
      end
      if (rd_stb)
      begin
         case (addr)
            `OTT_A_CTRL:    nx.rdata = {20'h0, st.ctrl};
            `OTT_A_PICKUP:  nx.rdata = {16'h0, st.pickup_thr};
            `OTT_A_DEF_DLY: nx.rdata = {8'h0, st.def_delay};
            `OTT_A_TMULT:   nx.rdata = {16'h0, st.time_multiplier};
            `OTT_A_RST_DLY: nx.rdata = {8'h0, st.reset_delay_setting};
            `OTT_A_UMIN:    nx.rdata = {8'h0, st.user_min_delay};
            `OTT_A_NOMINAL: nx.rdata = {16'h0, st.nominal};
            `OTT_A_ANGLE:   nx.rdata = {16'h0, st.phase_char_angle};
            `OTT_A_VR_MAX:  nx.rdata = {16'h0, st.vr_max};
            `OTT_A_STATUS:  nx.rdata = {29'h0, st.blk, st.trip, st.picked};
            `OTT_A_TIMER:   nx.rdata = {8'h0, st.tmr};
            `OTT_A_DELAY:   nx.rdata = {8'h0, need};
            default:        nx.rdata = 32'h00000000;
         endcase
      end
      case (st.fsm)
         ott_pkg::OTT_ST_IDLE:
            if (sample_en)
               nx.fsm = ott_pkg::OTT_ST_DIV_I;
         ott_pkg::OTT_ST_DIV_I:
            if (div_done)
            begin
               nx.quo_i = div_q;
               nx.fsm = ott_pkg::OTT_ST_DIV_C;
            end
         ott_pkg::OTT_ST_DIV_C:
            if (div_done)
            begin
               nx.quo_c = div_q;
               nx.fsm = ott_pkg::OTT_ST_EVAL;
            end
         ott_pkg::OTT_ST_EVAL:
         begin
            nx.delay = scale(trip_a, st.time_multiplier);
            nx.floor_dly = scale(trip_b, st.time_multiplier);
            // Reset table holds tau/(1-ratio^alpha) per ratio step
            nx.rst_dly = (|st.quo_i[27:4]) ? 24'h000000 :
                         scale(rst_a, st.time_multiplier);
            nx.fsm = ott_pkg::OTT_ST_TIMER;
         end
         ott_pkg::OTT_ST_TIMER:
         begin
            nx.fsm = ott_pkg::OTT_ST_IDLE;
            nx.picked = pick_now;
            nx.blk = blk_now;
            if (!st.ctrl[`OTT_C_EN])
            begin
               nx.tmr = 24'h000000;
               nx.min_tmr = 24'h000000;
               nx.rst_tmr = 24'h000000;
               nx.trip = 1'b0;
            end
            else if (pick_now)
            begin
               nx.rst_tmr = 24'h000000;
               nx.tmr = tmr_inc;
               nx.min_tmr = min_inc;
               if (tmr_inc >= need && min_ok)
                  nx.trip = 1'b1;
            end
            else
            begin
               nx.trip = 1'b0;
               nx.min_tmr = 24'h000000;
               // One sample is well inside two power cycles
               if (is_definite_time_curve || rmode == ott_pkg::OTT_RST_INST)
               begin
                  nx.tmr = 24'h000000;
                  nx.rst_tmr = 24'h000000;
               end
               else if (st.tmr != 24'h000000)
               begin
                  nx.rst_tmr = inc(st.rst_tmr);
                  if (inc(st.rst_tmr) >= hold)
                  begin
                     nx.tmr = 24'h000000;
                     nx.rst_tmr = 24'h000000;
                  end
               end
            end
         end
         default: nx.fsm = ott_pkg::OTT_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         st <= '0;
         st.ctrl <= `OTT_CTRL_RST;
         st.time_multiplier <= `OTT_TMULT_RST;
      end
      else
         st <= nx;

   assign rdata   = st.rdata;
   assign pickup  = st.picked;
   assign trip    = st.trip;
   assign blocked = st.blk;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_TRIP_NEEDS_PICKUP: assert property (trip |-> pickup)
      else $error("trip without pickup");
   AST_TMR_ONLY_PICKED: assert property (
      st.tmr > $past(st.tmr) |-> st.picked)
      else $error("timer advanced below pickup");
   AST_DEFINITE_TIME_CURVE_DELAY: assert property (
      $rose(trip) && is_definite_time_curve |-> st.tmr >= st.def_delay)
      else $error("definite trip too early");
   AST_INV_FLOOR: assert property (
      $rose(trip) && is_inv |->
      st.tmr >= st.floor_dly && st.tmr >= st.delay)
      else $error("inverse trip below floor");
   AST_UMIN: assert property (
      $rose(trip) && is_inv && st.user_min_delay != 24'h000000 |->
      st.min_tmr >= st.user_min_delay)
      else $error("trip before user minimum delay");
   AST_INST_RST: assert property (
      st.fsm == ott_pkg::OTT_ST_TIMER && !pick_now &&
      (is_definite_time_curve || rmode == ott_pkg::OTT_RST_INST) |=>
      st.tmr == 24'h000000 && !trip)
      else $error("instant reset did not clear timer");
   AST_DEF_HOLD: assert property (
      st.tmr == 24'h000000 && $past(st.tmr) != 24'h000000 &&
      !st.picked && !is_definite_time_curve && rmode == ott_pkg::OTT_RST_DEF &&
      st.ctrl[`OTT_C_EN] |->
      $past(st.rst_tmr) + 24'h000001 >= st.reset_delay_setting)
      else $error("definite reset cleared early");
   AST_CAP: assert property (
      current_cap <= cap_pu && current_cap <= cap_in)
      else $error("current cap not the minimum");
   AST_BLOCK: assert property (blocked |-> !pickup && !trip)
      else $error("blocked element picked up");
   AST_SAMPLE_PACE: assert property (
      $rose(trip) |-> $past(st.fsm) == ott_pkg::OTT_ST_TIMER)
      else $error("trip outside sample update");
   AST_EVAL_BOUND: assert property (
      sample_en |-> ##[1:63] st.fsm == ott_pkg::OTT_ST_TIMER)
      else $error("sample evaluation overran");

   COV_TRIP_DEFINITE_TIME_CURVE: cover property ($rose(trip) && is_definite_time_curve);
   COV_TRIP_INV: cover property ($rose(trip) && is_inv);
   COV_DEF_RESET: cover property (
      $fell(st.tmr != 24'h000000) && rmode == ott_pkg::OTT_RST_DEF);
   COV_BLOCKED: cover property ($rose(blocked));
endmodule : ott_overcurrent_trip

/* bench/ott_overcurrent_trip_tb_top.sv */
// Self-checking bench for the overcurrent trip timing block
`include "ott_regs.svh"
module ott_overcurrent_trip_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk;
   logic        rst_n;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr_stb;
   logic        rd_stb;
   logic [31:0] rdata;
   logic [15:0] i_fund;
   logic [15:0] ang;
   logic [15:0] v_ln;
   logic        vref;
   logic        pickup;
   logic        trip;
   logic        blocked;
   logic [31:0] rv;
   int          fails;
   int          tests_run;
   // Short sample period keeps the run brief
   ott_overcurrent_trip #(.SAMPLE_DIV(64)) uut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .phase_a_current(i_fund), .phase_b_current(i_fund),
      .phase_c_current(i_fund), .phase_a_rms(i_fund),
      .phase_b_rms(i_fund), .phase_c_rms(i_fund),
      .negative_sequence_current(i_fund), .phase_a_angle(ang),
      .phase_b_angle(ang), .phase_c_angle(ang),
      .voltage_a_to_b(v_ln), .voltage_b_to_c(v_ln),
      .voltage_c_to_a(v_ln), .voltage_a_to_b_angle(ang),
      .voltage_b_to_c_angle(ang), .voltage_c_to_a_angle(ang),
      .phase_a_voltage(v_ln), .phase_b_voltage(v_ln),
      .phase_c_voltage(v_ln), .ref_voltage_valid(vref),
      .ref_memory_valid(vref), .pickup(pickup), .trip(trip),
      .blocked(blocked));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the read edge
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 rv = rdata;
   endtask : rd
   task automatic wait_pu(input logic v);
      int n;
      n = 0;
      while (pickup !== v && n < 200)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk("pickup", {31'h0, pickup}, {31'h0, v});
   endtask : wait_pu
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   initial
   begin
      {rst_n, addr, wdata, wr_stb, rd_stb, vref} = '0;
      {i_fund, ang, v_ln} = '0;
      fails = 0;
      tests_run = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(`OTT_A_CTRL);
      chk("ctrl", rv, 32'h0);
      rd(`OTT_A_TMULT);
      chk("tmult", rv, 32'h100);
      rd(4'hd);
      chk("unmapped", rv, 32'h0);
      wr(`OTT_A_STATUS, 32'hffffffff);
      rd(`OTT_A_STATUS);
      chk("status ro", rv, 32'h0);
      wr(`OTT_A_PICKUP, 32'h64);
      wr(`OTT_A_DEF_DLY, 32'h3);
      wr(`OTT_A_CTRL, 32'h1);
      @(posedge clk) i_fund <= 16'h00c8;
      wait_pu(1'b1);
      repeat (62) @(posedge clk);
      #1 chk("trip early", {31'h0, trip}, 32'h0);
      repeat (68) @(posedge clk);
      #1 chk("trip", {31'h0, trip}, 32'h1);
      chk("blocked", {31'h0, blocked}, 32'h0);
      rd(`OTT_A_TIMER);
      chk("timer", rv, 32'h3);
      @(posedge clk) i_fund <= 16'h0032;
      wait_pu(1'b0);
      chk("trip drop", {31'h0, trip}, 32'h0);
      rd(`OTT_A_TIMER);
      chk("timer drop", rv, 32'h0);
      wr(`OTT_A_CTRL, 32'h821);
      @(posedge clk) i_fund <= 16'h00c8;
      repeat (130) @(posedge clk);
      #1 chk("blocked", {31'h0, blocked}, 32'h1);
      chk("blocked pickup", {31'h0, pickup}, 32'h0);
      @(posedge clk) vref <= 1'b1;
      wait_pu(1'b1);
      chk("unblocked", {31'h0, blocked}, 32'h0);
      @(posedge clk) i_fund <= 16'h0032;
      wait_pu(1'b0);
      // Floor at the cap outlasts the curve delay at ratio two
      wr(`OTT_A_NOMINAL, 32'h64);
      wr(`OTT_A_TABLE, 32'h02000002);
      wr(`OTT_A_TABLE, 32'h14000004);
      wr(`OTT_A_RST_DLY, 32'h2);
      wr(`OTT_A_CTRL, 32'hb);
      @(posedge clk) i_fund <= 16'h00c8;
      wait_pu(1'b1);
      repeat (190) @(posedge clk);
      #1 chk("inv floor", {31'h0, trip}, 32'h0);
      repeat (4) @(posedge clk);
      #1 chk("inv trip", {31'h0, trip}, 32'h1);
      rd(`OTT_A_DELAY);
      chk("delay", rv, 32'h4);
      @(posedge clk) i_fund <= 16'h0032;
      wait_pu(1'b0);
      chk("inv trip drop", {31'h0, trip}, 32'h0);
      rd(`OTT_A_TIMER);
      chk("timer hold", rv, 32'h4);
      repeat (64) @(posedge clk);
      rd(`OTT_A_TIMER);
      chk("timer reset", rv, 32'h0);
      complete_run();
   end
   initial
   begin
      #200000;
      fails++;
      complete_run();
   end
endmodule : ott_overcurrent_trip_tb_top
